// file: logic/rcp_pkg.sv
// Package for the reset cause and power gating block: offsets, fields, resets, types
package rcp_pkg;
  // Register byte addresses on APB
  localparam logic [11:0] RCP_GATE_ADDR = 12'hf80;
  localparam logic [11:0] RCP_CAUSE_ADDR = 12'hff0;
  localparam logic [11:0] RCP_MODE_ADDR = 12'hfe0;
  localparam logic [11:0] RCP_HW_ADDR = 12'hfe4;
  // Cause record field positions
  localparam int RCP_POR_BIT = 7;
  localparam int RCP_DSR_BIT = 6;
  localparam int RCP_WDT_BIT = 5;
  localparam int RCP_PIN_BIT = 4;
  localparam int RCP_LOW_BIT = 0;
  // Power gate field positions
  localparam int RCP_AMP_BIT = 7;
  localparam int RCP_BOD_BIT = 4;
  localparam int RCP_TMP_BIT = 3;
  localparam int RCP_ADC_BIT = 2;
  localparam int RCP_CMP_BIT = 1;
  // Reset values and masks
  localparam logic [7:0] RCP_GATE_RESET = 8'h80;
  localparam logic [7:0] RCP_GATE_WMASK = 8'h9e;
  localparam logic [7:0] RCP_CAUSE_RESET = 8'h80;
  localparam logic [7:0] RCP_FLAG_MASK = 8'hf0;
  // Cause flag patterns
  localparam logic [3:0] RCP_C_POR = 4'h8;
  localparam logic [3:0] RCP_C_PIN = 4'h1;
  localparam logic [3:0] RCP_C_WDT = 4'h2;
  localparam logic [3:0] RCP_C_DGPIO = 4'h4;
  localparam logic [3:0] RCP_C_DWDT = 4'h6;
  // Operating modes
  typedef enum logic [1:0] {
    RCP_ACTIVE = 2'b00,
    RCP_PAUSE = 2'b01,
    RCP_DEEP = 2'b10
  } rcp_mode_t;
  // System events that feed the cause record and the sleep-mode exits
  typedef struct packed {
    logic por;
    logic pin_rst;
    logic wdt_rst;
    logic wdt_irq;
    logic dbg_rst;
    logic dbg_pin_low;
    logic gpio_wake;
    logic irq;
  } rcp_event_t;
  // Peripheral gating outputs
  typedef struct packed {
    logic amp_en;
    logic bod_en;
    logic tmp_en;
    logic adc_en;
    logic cmp_en;
  } rcp_gate_t;
endpackage

// file: logic/rcp_top.sv
// Reset cause record, low-supply flag, sleep modes and peripheral power gating
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Cause record read-only; read clears upper four
// - Same address: read cause, write watchdog control
// - Power-on reset sets bit 7 only
// - Pin reset sets bit 4 only
// - Watchdog reset sets bit 5 only
// - Debugger or debug-pin reset records power-on
// - GPIO deep-sleep wake sets bit 6 only
// - Watchdog deep-sleep wake sets bits 6, 5
// - Power-on flag cleared by watchdog, wake, read
// - Wake flag cleared by POR, awake watchdog
// - Bit 0 live supply-low; bits 3..1 zero
// - Deep sleep stops clocks, processor and PC
// - Deep sleep hands crystal pins to GPIO
// - Pause keeps clock, stops processor and PC
// - Pause ends on interrupt, watchdog, power-on or pin reset
// - Power gate register bit layout at 0xf80
// - Disable bit gates block clock or power
// - Only power-on reset loads power gate register
// - Amplifier disable resets 1; enabled stays in sleep
// - Brown-out active needs bit clear and option
// - Gate bit overrides block's own enables
// - Register access never alters supply-low flag
module rcp_top
  import rcp_pkg::*;
(
  // Clock, resets and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System events and levels
  input wire rcp_event_t evt,
  input wire logic supply_low,
  input wire logic brownout_always_on_option,
  input wire logic wdt_enabled,
  input wire logic wdt_osc_enabled,
  input wire logic xtal_enabled,
  // Watchdog control write port
  output logic wdt_ctl_we,
  output logic [7:0] wdt_ctl_data,
  // Clocking and power outputs
  output logic osc_run,
  output logic sysclk_run,
  output logic cpu_run,
  output logic pc_run,
  output logic wdt_osc_run,
  output logic periph_run,
  output logic xtal_pins_osc,
  output var rcp_gate_t gate,
  output logic [1:0] mode
);

  // Registers
  logic [7:0] gate_reg; // Power gate, kept across system resets
  logic [3:0] flags_reg; // Upper cause flags
  logic low_reg; // Registered copy of supply level
  rcp_mode_t mode_reg; // Current sleep mode
  logic [3:0] flags_next;
  logic [3:0] set_v;
  logic [3:0] clr_v;
  logic any_evt;

  // APB decode; no wait states so pready is always high from reset
  logic wr_acc;
  logic rd_acc;
  logic hit;
  assign wr_acc = ce && psel && penable && pwrite;
  assign rd_acc = ce && psel && penable && !pwrite;
  assign hit = (paddr == RCP_GATE_ADDR) || (paddr == RCP_CAUSE_ADDR) ||
               (paddr == RCP_MODE_ADDR) || (paddr == RCP_HW_ADDR);

  // Cause event decode: one pattern per event, earlier branches win
  // The debug pin counts as a cause only in deep sleep; awake it is an ordinary pin
  always_comb
  begin
    set_v = 4'h0;
    clr_v = 4'h0;
    any_evt = 1'b1;
    if (evt.dbg_rst || (evt.dbg_pin_low && mode_reg == RCP_DEEP))
    begin
      set_v = RCP_C_POR;
      clr_v = ~RCP_C_POR;
    end
    else if (evt.pin_rst)
    begin
      set_v = RCP_C_PIN;
      clr_v = ~RCP_C_PIN;
    end
    else if ((evt.wdt_rst || evt.wdt_irq) && mode_reg == RCP_DEEP)
    begin
      set_v = RCP_C_DWDT;
      clr_v = ~RCP_C_DWDT;
    end
    else if (evt.gpio_wake && mode_reg == RCP_DEEP)
    begin
      set_v = RCP_C_DGPIO;
      clr_v = ~RCP_C_DGPIO;
    end
    else if (evt.wdt_rst)
    begin
      set_v = RCP_C_WDT;
      clr_v = ~RCP_C_WDT;
    end
    else
    begin
      any_evt = 1'b0;
    end
  end

  // Read clears first, then event pattern overrides the result
  always_comb
  begin
    flags_next = flags_reg;
    if (rd_acc && paddr == RCP_CAUSE_ADDR)
    begin
      flags_next = 4'h0;
    end
    if (any_evt)
    begin
      flags_next = (flags_next & ~clr_v) | set_v;
    end
  end

  // Cause flags: power-on loads power-on pattern
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      flags_reg <= RCP_CAUSE_RESET[7:4];
    end
    else if (ce)
    begin
      flags_reg <= flags_next;
    end
  end

  // Supply-low copy follows the pin only, never bus access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_reg <= 1'b0;
    end
    else if (ce)
    begin
      low_reg <= supply_low;
    end
  end

  // Power gate register: reset by power-on only; reserved bits forced zero
  // Kept apart from presetn so a pin or watchdog reset keeps the chosen gating
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      gate_reg <= RCP_GATE_RESET;
    end
    else if (wr_acc && paddr == RCP_GATE_ADDR)
    begin
      gate_reg <= pwdata[7:0] & RCP_GATE_WMASK;
    end
  end

  // Mode: software requests sleep via mode register; wake events return active
  // Sleep is left only through events; a request written while asleep is ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= RCP_ACTIVE;
    end
    else if (ce)
    begin
      case (mode_reg)
        RCP_ACTIVE:
        begin
          if (wr_acc && paddr == RCP_MODE_ADDR)
          begin
            // Only valid codes accepted; others ignored
            case (pwdata[1:0])
              2'b01: mode_reg <= RCP_PAUSE;
              2'b10: mode_reg <= RCP_DEEP;
              default: mode_reg <= RCP_ACTIVE;
            endcase
          end
        end
        RCP_PAUSE:
        begin
          if (evt.irq || evt.wdt_irq || evt.wdt_rst || evt.por || evt.pin_rst)
          begin
            mode_reg <= RCP_ACTIVE;
          end
        end
        RCP_DEEP:
        begin
          // Wake from deep sleep: watchdog, GPIO, pin or debug pin
          if (evt.wdt_irq || evt.wdt_rst || evt.gpio_wake || evt.pin_rst ||
              evt.dbg_pin_low)
          begin
            mode_reg <= RCP_ACTIVE;
          end
        end
        default: mode_reg <= RCP_ACTIVE;
      endcase
    end
  end

  // Run enables per mode; a real chip stops this clock in deep sleep too
  // Trade-off: enables lag the mode by one cycle so that each comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_run <= 1'b1;
      sysclk_run <= 1'b1;
      cpu_run <= 1'b1;
      pc_run <= 1'b1;
      wdt_osc_run <= 1'b0;
      periph_run <= 1'b1;
      xtal_pins_osc <= 1'b0;
    end
    else if (ce)
    begin
      osc_run <= (mode_reg != RCP_DEEP);
      sysclk_run <= (mode_reg != RCP_DEEP);
      cpu_run <= (mode_reg == RCP_ACTIVE);
      pc_run <= (mode_reg == RCP_ACTIVE);
      wdt_osc_run <= wdt_osc_enabled && (mode_reg != RCP_DEEP || wdt_enabled);
      periph_run <= (mode_reg != RCP_DEEP);
      xtal_pins_osc <= xtal_enabled && (mode_reg != RCP_DEEP);
    end
  end

  // Peripheral enables: gate bit wins over block enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate <= '0;
    end
    else if (ce)
    begin
      gate.amp_en <= !gate_reg[RCP_AMP_BIT];
      gate.bod_en <= !gate_reg[RCP_BOD_BIT] && brownout_always_on_option;
      gate.tmp_en <= !gate_reg[RCP_TMP_BIT] && (mode_reg != RCP_DEEP);
      gate.adc_en <= !gate_reg[RCP_ADC_BIT] && (mode_reg != RCP_DEEP);
      gate.cmp_en <= !gate_reg[RCP_CMP_BIT] && (mode_reg != RCP_DEEP);
    end
  end

  // Watchdog control write strobe at the shared address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdt_ctl_we <= 1'b0;
      wdt_ctl_data <= 8'h00;
    end
    else if (ce)
    begin
      wdt_ctl_we <= wr_acc && paddr == RCP_CAUSE_ADDR;
      if (wr_acc && paddr == RCP_CAUSE_ADDR)
      begin
        wdt_ctl_data <= pwdata[7:0];
      end
    end
  end

  // APB read data registered in setup so access phase sees it
  // Read data is zero outside the access cycle so stale values never linger
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b1;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready <= 1'b1;
      pslverr <= psel && !penable && !hit;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          RCP_CAUSE_ADDR: prdata <= {24'h0, flags_reg, 3'b000, supply_low};
          RCP_GATE_ADDR: prdata <= {24'h0, gate_reg};
          RCP_MODE_ADDR: prdata <= {30'h0, mode_reg};
          RCP_HW_ADDR: prdata <= {31'h0, low_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign mode = mode_reg;

  // Assertions on the cause record
  cause_clear_a: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
    (rd_acc && paddr == RCP_CAUSE_ADDR && !any_evt) |=> flags_reg == 4'h0)
    else $error("cause flags not cleared by read");
  pin_flag_a: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
    (ce && evt.pin_rst && !evt.dbg_rst && !(evt.dbg_pin_low && mode_reg == RCP_DEEP))
    |=> flags_reg == RCP_C_PIN)
    else $error("pin reset pattern wrong");

  // Wake patterns are decoded here from the raw events, not from the decoder
  deep_wdt_a: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
    (ce && mode_reg == RCP_DEEP && (evt.wdt_rst || evt.wdt_irq) && !evt.dbg_rst &&
     !evt.dbg_pin_low && !evt.pin_rst) |=> flags_reg == RCP_C_DWDT)
    else $error("deep watchdog pattern wrong");
  gpio_wake_a: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
    (ce && mode_reg == RCP_DEEP && evt.gpio_wake && !evt.dbg_rst && !evt.dbg_pin_low &&
     !evt.pin_rst && !evt.wdt_rst && !evt.wdt_irq) |=> flags_reg == RCP_C_DGPIO)
    else $error("gpio wake pattern wrong");
  awake_wdt_a: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
    (ce && mode_reg != RCP_DEEP && evt.wdt_rst && !evt.dbg_rst && !evt.pin_rst)
    |=> flags_reg == RCP_C_WDT)
    else $error("watchdog reset pattern wrong");

  // Assertions on the bus side
  low_live_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && psel && !penable && !pwrite && paddr == RCP_CAUSE_ADDR)
    |=> prdata[3:0] == {3'b000, $past(supply_low)})
    else $error("live supply flag wrong on read");
  wdt_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == RCP_CAUSE_ADDR) |=> wdt_ctl_we)
    else $error("watchdog write lost");

  // Assertions on the power gate
  gate_hold_a: assert property (@(posedge pclk) disable iff (!por_n)
    !(wr_acc && paddr == RCP_GATE_ADDR) |=> gate_reg == $past(gate_reg))
    else $error("gate register changed without write");
  gate_rsv_a: assert property (@(posedge pclk) disable iff (!por_n)
    (gate_reg & ~RCP_GATE_WMASK) == 8'h00)
    else $error("reserved gate bits set");
  bod_gate_a: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
    (ce && gate_reg[RCP_BOD_BIT]) |=> !gate.bod_en)
    else $error("brownout enabled while disabled");
  amp_gate_a: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
    ce |=> gate.amp_en == !$past(gate_reg[RCP_AMP_BIT]))
    else $error("amplifier enable does not follow its bit");

  // Assertions on the sleep modes
  pause_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && mode_reg == RCP_PAUSE && evt.irq) |=> mode_reg == RCP_ACTIVE ##1 cpu_run)
    else $error("pause not left on interrupt");
  deep_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && mode_reg == RCP_DEEP) |=> !sysclk_run && !cpu_run && !xtal_pins_osc)
    else $error("clocks run in deep sleep");

  // Covers for the main scenarios
  pause_c: cover property (@(posedge pclk) mode_reg == RCP_PAUSE ##[1:20] mode_reg == RCP_ACTIVE);
  deep_c: cover property (@(posedge pclk) mode_reg == RCP_DEEP ##[1:20] flags_reg[2]);
  read_c: cover property (@(posedge pclk) rd_acc && paddr == RCP_CAUSE_ADDR && flags_reg != 0);
  collide_c: cover property (@(posedge pclk) rd_acc && paddr == RCP_CAUSE_ADDR && any_evt);

endmodule // rcp_top
`default_nettype wire

// file: tb/test_rcp_top.sv
// Self-checking bench for the reset cause and power gating block
`timescale 1ns/1ps
`default_nettype none
module test_rcp_top;
  import rcp_pkg::*;
  // Stimulus and observed signals
  logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, supply_low = 0;
  logic bo_opt = 1;
  logic ce = 1, wdt_en = 1, wosc_en = 1, xtal_en = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, wdt_ctl_we, osc_run, sysclk_run, cpu_run, pc_run, wdt_osc_run;
  logic periph_run, xtal_pins_osc, err;
  logic [7:0] wdt_ctl_data, rd;
  logic [1:0] mode;
  rcp_event_t evt = '0;
  rcp_gate_t gate;
  int error_cnt = 0, tests_run = 0, we_cnt = 0;
  // Table rows: mode before event, event, expected record
  logic [7:0] rm [8] = '{8'h0, 8'h0, 8'h0, 8'h2, 8'h2, 8'h2, 8'h2, 8'h0};
  logic [7:0] re [8] = '{8'h40, 8'h20, 8'h08, 8'h04, 8'h02, 8'h20, 8'h10, 8'h10};
  logic [7:0] rx [8] = '{8'h10, 8'h20, 8'h80, 8'h80, 8'h40, 8'h60, 8'h60, 8'h00};
  // 200 MHz clock
  always #2.5 pclk = ~pclk;
  // Count watchdog control strobes to catch doubled pulses
  always @(posedge pclk) if (wdt_ctl_we === 1'b1) we_cnt <= we_cnt + 1;
  rcp_top dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt(evt), .supply_low(supply_low),
    .brownout_always_on_option(bo_opt), .wdt_enabled(wdt_en), .wdt_osc_enabled(wosc_en),
    .xtal_enabled(xtal_en), .wdt_ctl_we(wdt_ctl_we), .wdt_ctl_data(wdt_ctl_data),
    .osc_run(osc_run), .sysclk_run(sysclk_run), .cpu_run(cpu_run), .pc_run(pc_run),
    .wdt_osc_run(wdt_osc_run), .periph_run(periph_run), .xtal_pins_osc(xtal_pins_osc),
    .gate(gate), .mode(mode));
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task close_out();
    $display("counts: %0d compares, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One APB transfer; ev is pulsed in the access cycle to collide with it
  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [7:0] ev);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    evt <= rcp_event_t'(ev);
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata[7:0];
    err = pslverr;
    evt <= '0; psel <= 0; penable <= 0;
    // A slave that never answers ends the run
    if (n >= 20)
    begin
      error_cnt++;
      close_out();
    end
  endtask
  // Single-cycle event pulse
  task pulse(input logic [7:0] e);
    @(posedge pclk);
    evt <= rcp_event_t'(e);
    @(posedge pclk);
    evt <= '0;
    repeat (2) @(posedge pclk);
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1; por_n <= 1;
    // Power-on state of both registers
    apb(0, RCP_CAUSE_ADDR, 0, 0); chk(rd, 8'h80);
    apb(0, RCP_GATE_ADDR, 0, 0); chk(rd, 8'h80);
    chk(gate, 5'b01111);
    done("reset");
    // Table of cause events, each read twice
    for (int i = 0; i < 8; i++)
    begin
      if (rm[i] != 0) apb(1, RCP_MODE_ADDR, rm[i], 0);
      pulse(re[i]);
      apb(0, RCP_CAUSE_ADDR, 0, 0); chk(rd, rx[i]);
      apb(0, RCP_CAUSE_ADDR, 0, 0); chk(rd, 8'h00);
    end
    done("table");
    // Shared address and live low-supply flag
    supply_low <= 1;
    apb(1, RCP_CAUSE_ADDR, 8'h5a, 0);
    repeat (3) @(posedge pclk);
    chk(we_cnt, 1); chk(wdt_ctl_data, 8'h5a);
    apb(0, RCP_CAUSE_ADDR, 0, 0); chk(rd, 8'h01);
    apb(0, RCP_HW_ADDR, 0, 0); chk(rd, 8'h01);
    supply_low <= 0;
    apb(0, 12'h004, 0, 0); chk(err, 1'b1);
    done("address");
    // Event lands in the same cycle as a clearing read
    apb(0, RCP_CAUSE_ADDR, 0, 8'h40);
    apb(0, RCP_CAUSE_ADDR, 0, 0); chk(rd, 8'h10);
    // Awake watchdog clears the wake flag
    apb(1, RCP_MODE_ADDR, 8'h2, 0);
    pulse(8'h02);
    pulse(8'h20);
    apb(0, RCP_CAUSE_ADDR, 0, 0); chk(rd, 8'h20);
    done("collide");
    // Gate bits override enables
    apb(1, RCP_GATE_ADDR, 8'h1e, 0);
    repeat (2) @(posedge pclk); chk(gate, 5'b10000);
    bo_opt <= 0;
    apb(1, RCP_GATE_ADDR, 8'h00, 0);
    repeat (2) @(posedge pclk); chk(gate, 5'b10111);
    bo_opt <= 1;
    // Pause keeps clocks, stops processor; interrupt wakes
    apb(1, RCP_MODE_ADDR, 8'h1, 0);
    repeat (3) @(posedge pclk);
    chk({osc_run, sysclk_run, cpu_run, pc_run}, 4'b1100);
    chk({mode, xtal_pins_osc, wdt_osc_run}, 4'b0111);
    apb(0, RCP_MODE_ADDR, 0, 0); chk(rd, 8'h01);
    pulse(8'h01); chk(cpu_run, 1'b1);
    // Deep sleep stops everything but enabled amplifier, brown-out and watchdog oscillator
    apb(1, RCP_MODE_ADDR, 8'h2, 0);
    repeat (3) @(posedge pclk);
    chk({osc_run, sysclk_run, cpu_run, pc_run, periph_run, wdt_osc_run}, 6'b000001);
    chk(xtal_pins_osc, 1'b0);
    chk({gate.amp_en, gate.tmp_en}, 2'b10);
    wdt_en <= 0;
    repeat (2) @(posedge pclk); chk(wdt_osc_run, 1'b0);
    wdt_en <= 1;
    pulse(8'h02); chk(cpu_run, 1'b1);
    apb(1, RCP_MODE_ADDR, 8'h3, 0);
    @(posedge pclk); chk(mode, 2'b00);
    done("modes");
    // Only power-on reset reloads the gate register
    apb(1, RCP_GATE_ADDR, 8'h12, 0);
    @(posedge pclk); presetn <= 0;
    @(posedge pclk); presetn <= 1;
    apb(0, RCP_GATE_ADDR, 0, 0); chk(rd, 8'h12);
    @(posedge pclk); presetn <= 0; por_n <= 0;
    @(posedge pclk); presetn <= 1; por_n <= 1;
    apb(0, RCP_GATE_ADDR, 0, 0); chk(rd, 8'h80);
    apb(0, RCP_CAUSE_ADDR, 0, 0); chk(rd, 8'h80);
    done("por");
    // Clock enable low: a pin reset pulse is not taken
    ce <= 0;
    pulse(8'h40);
    ce <= 1;
    apb(0, RCP_CAUSE_ADDR, 0, 0); chk(rd, 8'h00);
    done("enable");
    close_out();
  end
endmodule // test_rcp_top
`default_nettype wire
